// file: src/mss_pkg.sv
package mss_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    localparam logic [1:0] START_VRAMP = 2'h0;
    localparam logic [1:0] START_ILIM = 2'h1;
    localparam logic [1:0] START_KICK = 2'h2;
    localparam logic STOP_FREE = 1'b0;
    localparam logic STOP_SOFT = 1'b1;
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_OVERHEAT = 3'h1;
    localparam logic [2:0] FLT_OVERCURRENT = 3'h2;
    localparam logic [2:0] FLT_PHASE_LOSS = 3'h3;
    localparam logic [2:0] FLT_OVERLOAD = 3'h4;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_NONE = 2'h2;

    // ----------------------------------------------------------------
    // ranges and factory values
    // ----------------------------------------------------------------
    localparam logic [9:0] DELAY_MAX = 10'h258;
    localparam logic [9:0] DELAY_DEF = 10'h000;
    localparam logic [6:0] COMP_MAX = 7'h32;
    localparam logic [6:0] COMP_DEF = 7'h05;
    localparam logic [6:0] KICK_MIN = 7'h14;
    localparam logic [6:0] KICK_MAX = 7'h50;
    localparam logic [6:0] KICK_DEF = 7'h32;
    localparam logic [7:0] KICKT_MIN = 8'h01;
    localparam logic [7:0] KICKT_MAX = 8'h3c;
    localparam logic [7:0] KICKT_DEF = 8'h02;
    localparam logic [7:0] UP_MIN = 8'h01;
    localparam logic [7:0] UP_MAX = 8'h78;
    localparam logic [7:0] UP_DEF = 8'h14;
    localparam logic [7:0] DN_MIN = 8'h01;
    localparam logic [7:0] DN_MAX = 8'hb4;
    localparam logic [7:0] DN_DEF = 8'h14;
    localparam logic [8:0] ICAP_MIN = 9'h096;
    localparam logic [8:0] ICAP_MAX = 9'h190;
    localparam logic [8:0] ICAP_DEF = 9'h12c;
    localparam logic [11:0] INTV_MIN = 12'h001;
    localparam logic [11:0] INTV_MAX = 12'he10;
    localparam logic [11:0] INTV_DEF = 12'h0f0;
    localparam logic [5:0] OLC_MAX = 6'h3c;
    localparam logic [5:0] OLC_DEF = 6'h00;
    localparam logic [1:0] START_DEF = START_ILIM;
    localparam logic STOP_DEF = STOP_FREE;
    localparam logic GUARD_DEF = 1'b1;
    localparam logic STOPB_DEF = 1'b0;
    localparam logic [1:0] PAR_DEF = 2'h0;
    localparam logic [2:0] BAUD_MAX = 3'h4;
    localparam logic [2:0] BAUD_DEF = 3'h2;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] start_profile_select;
        logic [9:0] start_delay_time;
        logic stop_profile_select;
        logic [6:0] initial_voltage_comp;
        logic [6:0] kick_level;
        logic [7:0] kick_duration;
        logic [7:0] ramp_up_time;
        logic [7:0] ramp_down_time;
        logic [8:0] start_current_cap;
        logic [11:0] min_restart_interval;
        logic early_bypass_guard_en;
        logic [5:0] overload_time_coeff;
        logic serial_stop_bits;
        logic [1:0] serial_parity_sel;
        logic [2:0] serial_baud_sel;
    } mss_param_t;

    typedef struct packed {
        logic [2:0] fault_record_now;
        logic [2:0] fault_record_prev;
        logic [2:0] fault_record_prev2;
    } mss_faults_t;

    localparam mss_param_t PARAM_DEF = '{
        START_DEF, DELAY_DEF, STOP_DEF, COMP_DEF, KICK_DEF, KICKT_DEF, UP_DEF,
        DN_DEF, ICAP_DEF, INTV_DEF, GUARD_DEF, OLC_DEF, STOPB_DEF, PAR_DEF, BAUD_DEF};

    typedef enum logic [2:0] {
        ST_STOP = 3'b000,
        ST_DELAY = 3'b001,
        ST_KICK = 3'b010,
        ST_RAMP = 3'b011,
        ST_RUN = 3'b100,
        ST_SOFTSTOP = 3'b101
    } mss_state_t;

endpackage

// file: src/mss_sequencer.sv
`timescale 1ns/1ns
module mss_sequencer (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic START_CMD,
    input wire logic STOP_CMD,
    input wire logic PARAM_WR,
    input wire mss_pkg::mss_param_t PARAM_IN,
    input wire logic FACTORY_RESTORE,
    input wire logic FAULT_HISTORY_CLEAR,
    input wire logic FAULT_VALID,
    input wire logic [2:0] FAULT_CODE,
    input wire logic AT_CURRENT_CAP,
    input wire logic BYPASS_CLOSED,
    output logic [6:0] VOLTAGE_REF,
    output logic [8:0] CURRENT_LIMIT,
    output logic CURRENT_LIMIT_EN,
    output logic WARN_NO,
    output logic WARN_NC,
    output logic [9:0] DELAY_COUNTDOWN,
    output logic RESTART_BLOCKED,
    output logic EARLY_BYPASS_FAULT,
    output logic [5:0] OL_COEFF_ACTIVE,
    output logic [2:0] SEQ_STATE,
    output mss_pkg::mss_param_t PARAM_SHOW,
    output mss_pkg::mss_faults_t FAULTS,
    output logic SER_TWO_STOP,
    output logic [1:0] SER_PARITY,
    output logic [14:0] SER_BAUD
);
    import mss_pkg::*;

    // ----------------------------------------------------------------
    // time base and parameter store
    // ----------------------------------------------------------------
    logic [16:0] tick_cnt_reg;
    logic tick_reg;
    logic [9:0] ms_cnt_reg;
    logic sec_reg;
    mss_param_t shadow_reg;
    mss_param_t active_reg;
    mss_state_t state_reg;
    mss_state_t state_next;
    logic [9:0] delay_reg;
    logic [11:0] intv_reg;
    logic [7:0] sec_cnt_reg;
    logic [6:0] v_reg;
    logic [10:0] frac_reg;
    logic [7:0] since_start_reg;

    function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo,
                                      input logic [11:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // last tick count of one percent step; 100 steps span the set seconds
    function automatic logic [10:0] step_ticks(input logic [7:0] secs);
        step_ticks = 11'(secs) * 11'(TICKS_PER_S / int'(PCT_FULL)) - 11'h001;
    endfunction

    function automatic mss_param_t clamp(input mss_param_t p, input mss_param_t old);
        mss_param_t r;
        r = p;
        if (p.start_profile_select > START_KICK) r.start_profile_select = old.start_profile_select;
        if (p.start_delay_time > DELAY_MAX) r.start_delay_time = old.start_delay_time;
        if (p.initial_voltage_comp > COMP_MAX) r.initial_voltage_comp = old.initial_voltage_comp;
        if (!in_range(12'(p.kick_level), 12'(KICK_MIN), 12'(KICK_MAX)))
            r.kick_level = old.kick_level;
        if (!in_range(12'(p.kick_duration), 12'(KICKT_MIN), 12'(KICKT_MAX)))
            r.kick_duration = old.kick_duration;
        if (!in_range(12'(p.ramp_up_time), 12'(UP_MIN), 12'(UP_MAX)))
            r.ramp_up_time = old.ramp_up_time;
        if (!in_range(12'(p.ramp_down_time), 12'(DN_MIN), 12'(DN_MAX)))
            r.ramp_down_time = old.ramp_down_time;
        if (!in_range(12'(p.start_current_cap), 12'(ICAP_MIN), 12'(ICAP_MAX)))
            r.start_current_cap = old.start_current_cap;
        if (!in_range(p.min_restart_interval, INTV_MIN, INTV_MAX))
            r.min_restart_interval = old.min_restart_interval;
        if (p.overload_time_coeff > OLC_MAX) r.overload_time_coeff = old.overload_time_coeff;
        if (p.serial_parity_sel > PAR_NONE[1:0]) r.serial_parity_sel = old.serial_parity_sel;
        if (p.serial_baud_sel > BAUD_MAX) r.serial_baud_sel = old.serial_baud_sel;
        clamp = r;
    endfunction

    always_ff @(posedge MCLK) begin
        if (SYS_RST || tick_cnt_reg == 17'(TICK_CYC - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 17'h1;
        end
        tick_reg <= !SYS_RST && tick_cnt_reg == 17'(TICK_CYC - 1);
    end

    always_ff @(posedge MCLK) begin
        sec_reg <= 1'b0;
        if (SYS_RST) begin
            ms_cnt_reg <= '0;
        end else if (tick_reg) begin
            if (ms_cnt_reg == 10'(TICKS_PER_S - 1)) begin
                ms_cnt_reg <= '0;
                sec_reg <= 1'b1;
            end else begin
                ms_cnt_reg <= ms_cnt_reg + 10'h1;
            end
        end
    end

    // writes land in the shadow copy; the engine only sees them when stopped
    always_ff @(posedge MCLK) begin
        if (SYS_RST || FACTORY_RESTORE) begin
            shadow_reg <= PARAM_DEF;
        end else if (PARAM_WR) begin
            shadow_reg <= clamp(PARAM_IN, shadow_reg);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            active_reg <= PARAM_DEF;
        end else if (state_reg == ST_STOP) begin
            active_reg <= shadow_reg;
        end
    end

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STOP: if (START_CMD && intv_reg == '0) state_next = ST_DELAY;
            ST_DELAY: begin
                if (STOP_CMD) state_next = ST_STOP;
                else if (delay_reg == '0)
                    state_next = (active_reg.start_profile_select == START_KICK) ?
                                 ST_KICK : ST_RAMP;
            end
            ST_KICK: begin
                if (STOP_CMD) state_next = ST_STOP;
                else if (sec_cnt_reg == active_reg.kick_duration) state_next = ST_RAMP;
            end
            ST_RAMP: begin
                if (STOP_CMD) state_next = ST_STOP;
                else if (v_reg == PCT_FULL) state_next = ST_RUN;
            end
            ST_RUN: begin
                if (STOP_CMD)
                    state_next = (active_reg.stop_profile_select == STOP_SOFT) ?
                                 ST_SOFTSTOP : ST_STOP;
            end
            ST_SOFTSTOP: if (v_reg == '0) state_next = ST_STOP;
            default: state_next = ST_STOP;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) state_reg <= ST_STOP;
        else state_reg <= state_next;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            delay_reg <= '0;
        end else if (state_reg == ST_STOP) begin
            delay_reg <= active_reg.start_delay_time;
        end else if (state_reg == ST_DELAY && sec_reg && delay_reg != '0) begin
            delay_reg <= delay_reg - 10'h1;
        end
    end

    // restart interval counts from each start command taken
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            intv_reg <= '0;
        end else if (state_reg == ST_STOP && state_next == ST_DELAY) begin
            intv_reg <= active_reg.min_restart_interval;
        end else if (sec_reg && intv_reg != '0) begin
            intv_reg <= intv_reg - 12'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST || state_reg != state_next) sec_cnt_reg <= '0;
        else if (sec_reg && sec_cnt_reg != 8'hff) sec_cnt_reg <= sec_cnt_reg + 8'h1;
    end

    // one percent step each time the fraction of the ramp time in ms elapses;
    // time per step = ramp_s * 1000 / 100 ticks, so step every 10*ramp_s ticks
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            v_reg <= '0;
            frac_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_STOP, ST_DELAY: begin
                    v_reg <= '0;
                    frac_reg <= '0;
                end
                ST_KICK: v_reg <= active_reg.kick_level;
                ST_RAMP: begin
                    if (state_next != state_reg) begin
                        frac_reg <= '0;
                    end else if (v_reg < active_reg.initial_voltage_comp &&
                                 active_reg.start_profile_select != START_KICK) begin
                        v_reg <= active_reg.initial_voltage_comp;
                    end else if (tick_reg && !(AT_CURRENT_CAP &&
                                 active_reg.start_profile_select == START_ILIM)) begin
                        if (frac_reg >= step_ticks(active_reg.ramp_up_time)) begin
                            frac_reg <= '0;
                            v_reg <= (v_reg >= PCT_FULL) ? PCT_FULL : v_reg + 7'h1;
                        end else begin
                            frac_reg <= frac_reg + 8'h1;
                        end
                    end
                end
                ST_RUN: begin
                    v_reg <= PCT_FULL;
                    frac_reg <= '0;
                end
                ST_SOFTSTOP: begin
                    if (tick_reg) begin
                        if (frac_reg >= step_ticks(active_reg.ramp_down_time)) begin
                            frac_reg <= '0;
                            v_reg <= (v_reg == '0) ? '0 : v_reg - 7'h1;
                        end else begin
                            frac_reg <= frac_reg + 8'h1;
                        end
                    end
                end
                default: v_reg <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // faults and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) since_start_reg <= '0;
        else if (state_reg == ST_DELAY) since_start_reg <= '0;
        else if (sec_reg && since_start_reg != 8'hff) since_start_reg <= since_start_reg + 8'h1;
    end

    // a new fault in the clear cycle still lands as the present fault
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            FAULTS <= '0;
        end else if (FAULT_VALID && FAULT_CODE != FLT_NONE && FAULT_CODE <= FLT_OVERLOAD) begin
            FAULTS.fault_record_now <= FAULT_CODE;
            FAULTS.fault_record_prev <= FAULT_HISTORY_CLEAR ? FLT_NONE : FAULTS.fault_record_now;
            FAULTS.fault_record_prev2 <= FAULT_HISTORY_CLEAR ? FLT_NONE :
                                         FAULTS.fault_record_prev;
        end else if (FAULT_HISTORY_CLEAR) begin
            FAULTS <= '0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            EARLY_BYPASS_FAULT <= 1'b0;
        end else if (START_CMD && state_reg == ST_STOP) begin
            EARLY_BYPASS_FAULT <= 1'b0;
        end else if (active_reg.early_bypass_guard_en && BYPASS_CLOSED &&
                     (state_reg == ST_KICK || state_reg == ST_RAMP) && since_start_reg == '0) begin
            EARLY_BYPASS_FAULT <= 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            VOLTAGE_REF <= '0;
            CURRENT_LIMIT <= '0;
            CURRENT_LIMIT_EN <= 1'b0;
            WARN_NO <= 1'b0;
            WARN_NC <= 1'b1;
            DELAY_COUNTDOWN <= '0;
            RESTART_BLOCKED <= 1'b0;
            OL_COEFF_ACTIVE <= '0;
            SEQ_STATE <= ST_STOP;
            PARAM_SHOW <= PARAM_DEF;
            SER_TWO_STOP <= STOPB_DEF;
            SER_PARITY <= PAR_DEF;
            SER_BAUD <= 15'h12c0;
        end else begin
            VOLTAGE_REF <= (state_next == ST_STOP) ? '0 : v_reg;
            CURRENT_LIMIT_EN <= active_reg.start_profile_select == START_ILIM &&
                                state_reg == ST_RAMP;
            CURRENT_LIMIT <= active_reg.start_current_cap;
            WARN_NO <= state_reg == ST_DELAY;
            WARN_NC <= state_reg != ST_DELAY;
            DELAY_COUNTDOWN <= (state_reg == ST_DELAY) ? delay_reg : '0;
            RESTART_BLOCKED <= intv_reg != '0;
            OL_COEFF_ACTIVE <= (active_reg.start_profile_select == START_VRAMP) ?
                               active_reg.overload_time_coeff : '0;
            SEQ_STATE <= state_reg;
            PARAM_SHOW <= shadow_reg;
            SER_TWO_STOP <= shadow_reg.serial_stop_bits;
            SER_PARITY <= shadow_reg.serial_parity_sel;
            unique case (shadow_reg.serial_baud_sel)
                3'h0: SER_BAUD <= 15'h04b0;
                3'h1: SER_BAUD <= 15'h0960;
                3'h2: SER_BAUD <= 15'h12c0;
                3'h3: SER_BAUD <= 15'h2580;
                default: SER_BAUD <= 15'h4b00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_warn_delay;
        @(posedge MCLK) disable iff (SYS_RST) (state_reg == ST_DELAY) |=> (WARN_NO && !WARN_NC);
    endproperty
    a_warn_delay: assert property (p_warn_delay) else $error("warning contact not set");

    property p_free_stop;
        @(posedge MCLK) disable iff (SYS_RST)
            (state_reg == ST_RUN && STOP_CMD && active_reg.stop_profile_select == STOP_FREE)
            |=> (VOLTAGE_REF == '0);
    endproperty
    a_free_stop: assert property (p_free_stop) else $error("free stop left voltage");

    property p_soft_stop;
        @(posedge MCLK) disable iff (SYS_RST)
            (state_reg == ST_RUN && STOP_CMD && active_reg.stop_profile_select == STOP_SOFT)
            |=> (state_reg == ST_SOFTSTOP);
    endproperty
    a_soft_stop: assert property (p_soft_stop) else $error("soft stop not entered");

    property p_kick_level;
        @(posedge MCLK) disable iff (SYS_RST)
            (state_reg == ST_KICK) ##1 (state_reg == ST_KICK) |-> (v_reg == active_reg.kick_level);
    endproperty
    a_kick_level: assert property (p_kick_level) else $error("kick level wrong");

    property p_interval;
        @(posedge MCLK) disable iff (SYS_RST)
            (state_reg == ST_STOP && intv_reg != '0) |=> (state_reg != ST_DELAY);
    endproperty
    a_interval: assert property (p_interval) else $error("start inside interval");

    property p_clear;
        @(posedge MCLK) disable iff (SYS_RST)
            (FAULT_HISTORY_CLEAR && !FAULT_VALID) |=> (FAULTS == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("history not cleared");

    property p_shift;
        @(posedge MCLK) disable iff (SYS_RST)
            (FAULT_VALID && FAULT_CODE == FLT_OVERLOAD && !FAULT_HISTORY_CLEAR)
            |=> (FAULTS.fault_record_prev == $past(FAULTS.fault_record_now));
    endproperty
    a_shift: assert property (p_shift) else $error("history not shifted");

    property p_hold;
        @(posedge MCLK) disable iff (SYS_RST)
            (state_reg == ST_RUN && !FACTORY_RESTORE) ##1 (state_reg == ST_RUN) |->
            $stable(active_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("active set changed while running");

endmodule

// file: verification/mss_motor_model.sv
`timescale 1ns/1ns
module mss_motor_model (
    input wire logic MCLK,
    input wire logic [6:0] VOLTAGE_REF,
    input wire logic [8:0] CURRENT_LIMIT,
    input wire logic CURRENT_LIMIT_EN,
    input wire logic BYPASS_SHUT,
    output logic AT_CURRENT_CAP,
    output logic BYPASS_CLOSED
);
    // ------------------------------------
    // stalled rotor draws about six times the applied voltage
    // ------------------------------------
    logic [9:0] amps_pct;
    logic at_cap_reg = 1'b0;
    logic bypass_reg = 1'b0;
    assign amps_pct = 10'(VOLTAGE_REF) * 10'h006;
    always @(posedge MCLK) begin
        at_cap_reg <= CURRENT_LIMIT_EN && (amps_pct >= 10'(CURRENT_LIMIT));
        // bypass closes at full voltage, or early when the bench asks for it
        bypass_reg <= BYPASS_SHUT || (VOLTAGE_REF == 7'h64);
    end
    assign AT_CURRENT_CAP = at_cap_reg;
    assign BYPASS_CLOSED = bypass_reg;
endmodule

// file: verification/motor_soft_start_sequencer_test.sv
`timescale 1ns/1ns
module motor_soft_start_sequencer_test;
    import mss_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic st = 1'b0, sp = 1'b0, wr_en = 1'b0, fr = 1'b0, fc = 1'b0, fv = 1'b0;
    logic [2:0] fcode = 3'h0;
    mss_param_t pin = PARAM_DEF;
    logic cap, byp, cl_en, w_no, w_nc, two_stop, blk, ebf;
    logic shut = 1'b0;
    logic [5:0] olc;
    logic [6:0] vref;
    logic [8:0] clim;
    logic [9:0] cdown;
    logic [2:0] state;
    logic [1:0] par;
    logic [14:0] baud;
    mss_param_t show;
    mss_faults_t flt;
    int err_total = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    mss_sequencer u_dut (.MCLK(mclk), .SYS_RST(rst), .START_CMD(st), .STOP_CMD(sp),
        .PARAM_WR(wr_en), .PARAM_IN(pin), .FACTORY_RESTORE(fr), .FAULT_HISTORY_CLEAR(fc),
        .FAULT_VALID(fv), .FAULT_CODE(fcode), .AT_CURRENT_CAP(cap), .BYPASS_CLOSED(byp),
        .VOLTAGE_REF(vref), .CURRENT_LIMIT(clim), .CURRENT_LIMIT_EN(cl_en), .WARN_NO(w_no),
        .WARN_NC(w_nc), .DELAY_COUNTDOWN(cdown), .RESTART_BLOCKED(blk), .EARLY_BYPASS_FAULT(ebf),
        .OL_COEFF_ACTIVE(olc), .SEQ_STATE(state), .PARAM_SHOW(show), .FAULTS(flt),
        .SER_TWO_STOP(two_stop), .SER_PARITY(par), .SER_BAUD(baud));
    mss_motor_model u_motor (.MCLK(mclk), .VOLTAGE_REF(vref), .CURRENT_LIMIT(clim),
        .CURRENT_LIMIT_EN(cl_en), .BYPASS_SHUT(shut), .AT_CURRENT_CAP(cap), .BYPASS_CLOSED(byp));
    // ------------------------------------
    // helpers
    // ------------------------------------
    task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input mss_param_t p);
        @(posedge mclk) pin <= p;
        wr_en <= 1'b1;
        @(posedge mclk) wr_en <= 1'b0;
        settle(3);
    endtask
    task automatic fault(input logic [2:0] c);
        @(posedge mclk) fv <= 1'b1;
        fcode <= c;
        @(posedge mclk) fv <= 1'b0;
        settle(2);
    endtask
    // mid-run reset clears the restart interval, then one start with p
    task automatic go(input mss_param_t p);
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wr(p);
        @(posedge mclk) st <= 1'b1;
        @(posedge mclk) st <= 1'b0;
        settle(5);
    endtask
    task automatic summarize();
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------
    // scenarios
    // ------------------------------------
    task automatic t_reset();
        chk("params", 96'(PARAM_DEF), 96'(show));
        chk("faults", 96'h0, 96'(flt));
        chk("baud", 96'h12c0, 96'(baud));
        chk("vref", 96'h0, 96'(vref));
        chk("contact", 96'h1, 96'({w_no, w_nc}));
    endtask
    task automatic t_serial();
        logic [14:0] rate [5] = '{15'h04b0, 15'h0960, 15'h12c0, 15'h2580, 15'h4b00};
        mss_param_t p;
        p = PARAM_DEF;
        for (int i = 0; i < 5; i++) begin
            p.serial_baud_sel = 3'(i);
            wr(p);
            chk("baud", 96'(rate[i]), 96'(baud));
        end
        for (int i = 0; i < 3; i++) begin
            p.serial_parity_sel = 2'(i);
            p.serial_stop_bits = 1'(i);
            wr(p);
            chk("parity", 96'(i), 96'(par));
            chk("stop", 96'(i & 1), 96'(two_stop));
        end
    endtask
    task automatic t_range();
        mss_param_t p;
        p = PARAM_DEF;
        p.kick_level = 7'h51;
        p.ramp_down_time = 8'hb4;
        p.stop_profile_select = STOP_SOFT;
        wr(p);
        chk("kick", 96'(KICK_DEF), 96'(show.kick_level));
        chk("down", 96'h0b4, 96'(show.ramp_down_time));
        chk("stop", 96'h1, 96'(show.stop_profile_select));
        p.kick_level = 7'h50;
        p.ramp_down_time = 8'hb5;
        p.ramp_up_time = 8'h79;
        wr(p);
        chk("kick", 96'h050, 96'(show.kick_level));
        chk("down", 96'h0b4, 96'(show.ramp_down_time));
        chk("up", 96'(UP_DEF), 96'(show.ramp_up_time));
        @(posedge mclk) fr <= 1'b1;
        @(posedge mclk) fr <= 1'b0;
        settle(3);
        chk("restore", 96'(PARAM_DEF), 96'(show));
    endtask
    task automatic t_fault();
        for (int c = 1; c <= 4; c++) fault(3'(c));
        chk("hist", 96'({3'h4, 3'h3, 3'h2}), 96'(flt));
        @(posedge mclk) fc <= 1'b1;
        @(posedge mclk) fc <= 1'b0;
        settle(3);
        chk("clear", 96'h0, 96'(flt));
        fault(FLT_OVERHEAT);
        chk("renew", 96'({FLT_OVERHEAT, 6'h0}), 96'(flt));
        fault(3'h5);
        chk("bad_code", 96'({FLT_OVERHEAT, 6'h0}), 96'(flt));
        @(posedge mclk) fv <= 1'b1;
        fcode <= FLT_PHASE_LOSS;
        fc <= 1'b1;
        @(posedge mclk) fv <= 1'b0;
        fc <= 1'b0;
        settle(2);
        chk("set_wins", 96'({FLT_PHASE_LOSS, 6'h0}), 96'(flt));
    endtask
    task automatic t_start();
        mss_param_t p;
        p = PARAM_DEF;
        p.start_delay_time = DELAY_MAX;
        wr(p);
        @(posedge mclk) st <= 1'b1;
        @(posedge mclk) st <= 1'b0;
        settle(3);
        chk("state", 96'h1, 96'(state));
        chk("count", 96'(DELAY_MAX), 96'(cdown));
        chk("vref", 96'h0, 96'(vref));
        chk("contact", 96'h2, 96'({w_no, w_nc}));
        @(posedge mclk) sp <= 1'b1;
        @(posedge mclk) sp <= 1'b0;
        settle(3);
        chk("state", 96'h0, 96'(state));
        chk("contact", 96'h1, 96'({w_no, w_nc}));
        @(posedge mclk) st <= 1'b1;
        @(posedge mclk) st <= 1'b0;
        settle(3);
        chk("refused", 96'h0, 96'(state));
        chk("blocked", 96'h1, 96'(blk));
    endtask
    task automatic t_run();
        mss_param_t p;
        p = PARAM_DEF;
        go(p);
        chk("state", 96'h3, 96'(state));
        chk("vref", 96'(COMP_DEF), 96'(vref));
        chk("cap_en", 96'h1, 96'(cl_en));
        chk("cap", 96'(ICAP_DEF), 96'(clim));
        chk("olc", 96'h0, 96'(olc));
        chk("blocked", 96'h1, 96'(blk));
        @(posedge mclk) shut <= 1'b1;
        settle(3);
        chk("early", 96'h1, 96'(ebf));
        @(posedge mclk) shut <= 1'b0;
        p.start_profile_select = START_VRAMP;
        p.overload_time_coeff = 6'h05;
        p.early_bypass_guard_en = 1'b0;
        go(p);
        chk("vref", 96'(COMP_DEF), 96'(vref));
        chk("cap_en", 96'h0, 96'(cl_en));
        chk("olc", 96'h05, 96'(olc));
        @(posedge mclk) shut <= 1'b1;
        settle(3);
        chk("early", 96'h0, 96'(ebf));
        @(posedge mclk) shut <= 1'b0;
        p.start_profile_select = START_KICK;
        go(p);
        chk("state", 96'h2, 96'(state));
        chk("vref", 96'(KICK_DEF), 96'(vref));
        @(posedge mclk) sp <= 1'b1;
        @(posedge mclk) sp <= 1'b0;
        settle(3);
        chk("state", 96'h0, 96'(state));
        chk("vref", 96'h0, 96'(vref));
    endtask
    // ------------------------------------
    // main and watchdog
    // ------------------------------------
    initial begin
        settle(11);
        @(posedge mclk) rst <= 1'b0;
        settle(2);
        t_reset();
        t_serial();
        t_range();
        t_fault();
        t_start();
        t_run();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        summarize();
    end
endmodule
